//--- rtl/debug_run_status_map.vh
// Purpose: register map and field positions of the debug run status block
// Assumes: 8-bit register port, one byte per address
// Notes:   definitions only
`ifndef DEBUG_RUN_STATUS_MAP_VH
`define DEBUG_RUN_STATUS_MAP_VH

// ****************************************
// widths
// ****************************************
`define DRS_ADDR_W        8
`define DRS_DATA_W        8
`define DRS_CNT_W         4
`define DRS_EV_N          3

// ****************************************
// register offsets
// ****************************************
`define DRS_CTRL_OFS      8'h00
`define DRS_STATUS_OFS    8'h01
`define DRS_IRQ_ST_OFS    8'h02
`define DRS_IRQ_MASK_OFS  8'h03

// ****************************************
// debug_control_register fields
// ****************************************
`define DRS_CTRL_ON_BIT     7
`define DRS_CTRL_LAUNCH_BIT 6
`define DRS_CTRL_BEGIN_BIT  0

// ****************************************
// debug_status_register fields
// ****************************************
`define DRS_ST_AHIT_BIT   7
`define DRS_ST_BHIT_BIT   6
`define DRS_ST_ACTIVE_BIT 5
`define DRS_ST_CNT_MSB    3
`define DRS_ST_CNT_LSB    0

// ****************************************
// event bits of irq status and mask
// ****************************************
`define DRS_EV_DONE_BIT   0
`define DRS_EV_AHIT_BIT   1
`define DRS_EV_BHIT_BIT   2

// ****************************************
// reset values and limits
// ****************************************
`define DRS_CTRL_RST      8'h00
`define DRS_ON_RST        1'b0
`define DRS_IRQ_MASK_RST  3'h0
`define DRS_CNT_RST       4'h0
`define DRS_CNT_MAX       4'h8
`define DRS_UNMAPPED_RD   8'h00

`endif

//--- rtl/debug_run_status.v
// Purpose: status side of the on-chip debug module: run control, hit flags,
//          fifo valid count, event interrupt
// Assumes: all inputs come from logic on ref_clk
// Notes:   read data appears the cycle after the read strobe
//
// How it works
// - status register ignores every write
// - comparator a flag cleared at start, sticky
// - comparator b flag cleared at start, sticky
// - active flag mirrors launch control while on
// - launch write with on bit also written as one sets flag; run end clears
// - full ends begin trace; trigger ends end
// - writing zero to launch or on stops
// - valid word count cleared at run start
// - count reports fifo words, zero to eight
// - fifo reads after the run ends never lower the count; while running it follows the fill level
// - launch write with on bit also written as one arms; completion clears launch
// - begin select picks trace style; events begin
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "debug_run_status_map.vh"

module debug_run_status (
  input  wire                     ref_clk,
  input  wire                     nrst,
  input  wire [`DRS_ADDR_W-1:0]   addr,
  input  wire [`DRS_DATA_W-1:0]   wdata,
  input  wire                     wr_stb,
  input  wire                     rd_stb,
  output reg  [`DRS_DATA_W-1:0]   rdata,
  input  wire                     comp_a_match,
  input  wire                     comp_b_match,
  input  wire                     fifo_full,
  input  wire                     trigger_event,
  input  wire                     event_only_mode,
  input  wire [`DRS_CNT_W-1:0]    fifo_fill_level,
  output wire                     run_armed,
  output wire                     trace_begin_mode,
  output reg                      run_start,
  output reg                      run_end,
  output wire                     irq
);

  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  // ****************************************
  // decode
  // ****************************************
  function sel;
    input [`DRS_ADDR_W-1:0] a;
    input [`DRS_ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  wire wr_ctrl;
  wire wr_irq_st;
  wire wr_irq_mask;

  assign wr_ctrl     = wr_stb & sel(addr, `DRS_CTRL_OFS);
  assign wr_irq_st   = wr_stb & sel(addr, `DRS_IRQ_ST_OFS);
  assign wr_irq_mask = wr_stb & sel(addr, `DRS_IRQ_MASK_OFS);
  // writes at the status offset decode to nothing

  // ****************************************
  // state registers
  // ****************************************
  reg  [1:0]              state_q;
  reg  [1:0]              state_d;
  reg                     on_q;
  reg                     on_d;
  reg                     launch_q;
  reg                     launch_d;
  reg                     begin_sel_q;
  reg                     begin_sel_d;
  reg                     a_hit_q;
  reg                     a_hit_d;
  reg                     b_hit_q;
  reg                     b_hit_d;
  reg  [`DRS_CNT_W-1:0]   cnt_q;
  reg  [`DRS_CNT_W-1:0]   cnt_d;
  reg  [`DRS_EV_N-1:0]    irq_st_q;
  reg  [`DRS_EV_N-1:0]    irq_mask_q;

  wire                    running;
  wire                    begin_eff;
  wire                    wr_on;
  wire                    wr_launch;
  wire                    start_req;
  wire                    stop_sw;
  wire                    stop_hw;
  wire                    stop_any;
  wire [`DRS_CNT_W-1:0]   fill_capped;
  wire [`DRS_EV_N-1:0]    ev;

  assign running   = state_q[1];
  assign begin_eff = begin_sel_q | event_only_mode;
  assign wr_on     = wdata[`DRS_CTRL_ON_BIT];
  assign wr_launch = wdata[`DRS_CTRL_LAUNCH_BIT];

  // ****************************************
  // run start and end conditions
  // ****************************************
  // arming needs the on bit written as one in the same write; an on bit already set does not count
  assign start_req = wr_ctrl & ~running & wr_on & wr_launch;

  // software stop by a zero in either control bit
  assign stop_sw   = wr_ctrl & running & (~wr_on | ~wr_launch);

  // hardware end depends on trace style
  assign stop_hw   = running &
                     ((begin_eff & fifo_full) |
                      (~begin_eff & trigger_event));

  assign stop_any  = stop_sw | stop_hw;

  // fill level clipped to the fifo depth
  assign fill_capped = (fifo_fill_level > `DRS_CNT_MAX) ?
                       `DRS_CNT_MAX : fifo_fill_level;

  // ****************************************
  // state machine
  // ****************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_req) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_any) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // control register
  // ****************************************
  always @* begin
    on_d        = on_q;
    launch_d    = launch_q;
    begin_sel_d = begin_sel_q;
    if (wr_ctrl) begin
      on_d = wr_on;
      // trace style is locked while a run is active
      if (~running) begin
        begin_sel_d = wdata[`DRS_CTRL_BEGIN_BIT];
      end
    end
    if (start_req) begin
      launch_d = 1'b1;
    end else if (stop_any) begin
      launch_d = 1'b0;
    end else if (wr_ctrl & ~running) begin
      launch_d = 1'b0;
    end
  end

  // ****************************************
  // hit flags
  // ****************************************
  always @* begin
    a_hit_d = a_hit_q;
    b_hit_d = b_hit_q;
    if (start_req) begin
      a_hit_d = 1'b0;
      b_hit_d = 1'b0;
    end else if (running) begin
      if (comp_a_match) begin
        a_hit_d = 1'b1;
      end
      if (comp_b_match) begin
        b_hit_d = 1'b1;
      end
    end
  end

  // ****************************************
  // fifo valid count
  // ****************************************
  always @* begin
    cnt_d = cnt_q;
    if (start_req) begin
      cnt_d = `DRS_CNT_RST;
    end else if (running) begin
      // follows the fill level, frozen once the run ends
      cnt_d = fill_capped;
    end
    // idle: held, fifo reads have no path here
  end

  // ****************************************
  // clocked state
  // ****************************************
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q     <= ST_IDLE;
      on_q        <= `DRS_ON_RST;
      launch_q    <= 1'b0;
      begin_sel_q <= 1'b0;
      a_hit_q     <= 1'b0;
      b_hit_q     <= 1'b0;
      cnt_q       <= `DRS_CNT_RST;
      run_start   <= 1'b0;
      run_end     <= 1'b0;
    end else begin
      state_q     <= state_d;
      on_q        <= on_d;
      launch_q    <= launch_d;
      begin_sel_q <= begin_sel_d;
      a_hit_q     <= a_hit_d;
      b_hit_q     <= b_hit_d;
      cnt_q       <= cnt_d;
      run_start   <= start_req;
      run_end     <= stop_any;
    end
  end

  // ****************************************
  // outputs to the rest of the unit
  // ****************************************
  assign run_armed        = launch_q & on_q;
  assign trace_begin_mode = begin_eff;

  // ****************************************
  // interrupt events
  // ****************************************
  assign ev[`DRS_EV_DONE_BIT] = stop_any;
  assign ev[`DRS_EV_AHIT_BIT] = a_hit_d & ~a_hit_q;
  assign ev[`DRS_EV_BHIT_BIT] = b_hit_d & ~b_hit_q;

  genvar gi;
  generate
    for (gi = 0; gi < `DRS_EV_N; gi = gi + 1) begin : g_irq
      // set wins over a write-one clear in the same cycle
      always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          irq_st_q[gi] <= 1'b0;
        end else if (ev[gi]) begin
          irq_st_q[gi] <= 1'b1;
        end else if (wr_irq_st & wdata[gi]) begin
          irq_st_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_q <= `DRS_IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_q <= wdata[`DRS_EV_N-1:0];
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);

  // ****************************************
  // read data
  // ****************************************
  reg [`DRS_DATA_W-1:0] rd_mux;

  always @* begin
    rd_mux = `DRS_UNMAPPED_RD;
    if (sel(addr, `DRS_CTRL_OFS)) begin
      rd_mux[`DRS_CTRL_ON_BIT]     = on_q;
      rd_mux[`DRS_CTRL_LAUNCH_BIT] = launch_q;
      rd_mux[`DRS_CTRL_BEGIN_BIT]  = begin_sel_q;
    end else if (sel(addr, `DRS_STATUS_OFS)) begin
      rd_mux[`DRS_ST_AHIT_BIT]   = a_hit_q;
      rd_mux[`DRS_ST_BHIT_BIT]   = b_hit_q;
      rd_mux[`DRS_ST_ACTIVE_BIT] = launch_q & on_q;
      rd_mux[`DRS_ST_CNT_MSB:`DRS_ST_CNT_LSB] = cnt_q;
    end else if (sel(addr, `DRS_IRQ_ST_OFS)) begin
      rd_mux[`DRS_EV_N-1:0] = irq_st_q;
    end else if (sel(addr, `DRS_IRQ_MASK_OFS)) begin
      rd_mux[`DRS_EV_N-1:0] = irq_mask_q;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `DRS_UNMAPPED_RD;
    end else if (rd_stb) begin
      rdata <= rd_mux;
    end else begin
      rdata <= `DRS_UNMAPPED_RD;
    end
  end

endmodule // debug_run_status
`default_nettype wire

//--- tb/debug_run_status_properties.sv
// Purpose: port checker for debug_run_status
// Assumes: one clock, nrst async active low
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "debug_run_status_map.vh"
module debug_run_status_properties (
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  input wire logic [`DRS_ADDR_W-1:0] addr,
  input wire logic [`DRS_DATA_W-1:0] wdata,
  input wire logic                   wr_stb,
  input wire logic                   rd_stb,
  input wire logic [`DRS_DATA_W-1:0] rdata,
  input wire logic                   fifo_full,
  input wire logic                   trigger_event,
  input wire logic                   event_only_mode,
  input wire logic                   run_armed,
  input wire logic                   trace_begin_mode,
  input wire logic                   run_start,
  input wire logic                   run_end,
  input wire logic                   irq
);
  wire ctl_wr = wr_stb && addr == `DRS_CTRL_OFS;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  arm_write_a: assert property (ctl_wr && wdata[7:6] == 2'b11 && !run_armed |=> run_start && run_armed)
    else $error("arming write did not start a run");
  stop_write_a: assert property (run_armed && ctl_wr && wdata[7:6] != 2'b11 |=> run_end && !run_armed)
    else $error("stop write did not end the run");
  full_end_a: assert property (run_armed && trace_begin_mode && fifo_full |=> run_end && !run_armed)
    else $error("full fifo did not end begin trace");
  trig_end_a: assert property (run_armed && !trace_begin_mode && trigger_event |=> run_end)
    else $error("trigger did not end end trace");
  end_cause_a: assert property (run_end |-> $past(run_armed))
    else $error("run end without a run");
  fall_end_a: assert property ($fell(run_armed) |-> run_end)
    else $error("armed dropped without run end");
  start_edge_a: assert property (run_start |-> run_armed && !$past(run_armed))
    else $error("run start not at arming");
  event_begin_a: assert property (event_only_mode |-> trace_begin_mode)
    else $error("event only mode not begin trace");
  read_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  cover property (run_start);
  cover property (run_end);
  cover property (irq);
endmodule // debug_run_status_properties
`default_nettype wire

//--- tb/fifo_host_model.sv
// Purpose: external debug host draining the trace fifo
// Assumes: total is the reported valid word count
// Notes:   one word taken each cycle, left shows words still queued
`timescale 1ns/1ps
`default_nettype none
module fifo_host_model (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [3:0] total,
  output logic      [3:0] left
);
  logic [3:0] left_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) left_q <= 4'h0;
    else if (load) left_q <= total;
    else if (left_q != 4'h0) left_q <= left_q - 4'h1;
  end
  assign left = left_q;
endmodule // fifo_host_model
`default_nettype wire

//--- tb/debug_run_status_tb.sv
// Purpose: self-checking bench for debug_run_status
// Assumes: 200 MHz ref_clk, register port master in tasks
// Notes:   host model drains the fifo after a run
`timescale 1ns/1ps
`default_nettype none
`include "debug_run_status_map.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("ERROR %s exp %h got %h", nm, e, g); error_cnt++; end end
module debug_run_status_tb;
  logic       ref_clk = 0, nrst = 0, wr_stb = 0, rd_stb = 0;
  logic [7:0] addr = 0, wdata = 0, v;
  logic       cmp_a = 0, cmp_b = 0, full = 0, trig = 0, evo = 0, drain = 0, load = 0;
  logic [3:0] fill = 0;
  wire  [7:0] rdata;
  wire  [3:0] left;
  wire  [3:0] lvl = drain ? left : fill;
  wire        armed, bmode, rstart, rend, irq;
  int         error_cnt = 0, n_compared = 0;
  debug_run_status dut_u (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .comp_a_match(cmp_a),
    .comp_b_match(cmp_b), .fifo_full(full), .trigger_event(trig), .event_only_mode(evo),
    .fifo_fill_level(lvl), .run_armed(armed), .trace_begin_mode(bmode),
    .run_start(rstart), .run_end(rend), .irq(irq));
  fifo_host_model host_u (.ref_clk(ref_clk), .nrst(nrst), .load(load), .total(v[3:0]),
    .left(left));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic t_reset;
    rd(`DRS_CTRL_OFS); `CHK("ctrl", `DRS_CTRL_RST, v)
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h00, v)
    rd(8'h10); `CHK("unmapped", `DRS_UNMAPPED_RD, v)
  endtask
  task automatic t_begin;
    wr(`DRS_IRQ_MASK_OFS, 8'h07);
    wr(`DRS_CTRL_OFS, 8'hc1);
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h20, v)
    @(posedge ref_clk) cmp_a <= 1'b1;
    @(posedge ref_clk) cmp_a <= 1'b0;
    fill <= 4'h5;
    wr(`DRS_STATUS_OFS, 8'hff);
    rd(`DRS_STATUS_OFS); `CHK("status", 8'ha5, v)
    @(posedge ref_clk) full <= 1'b1;
    repeat (2) @(posedge ref_clk);
    full <= 1'b0;
    #1 `CHK("armed", 1'b0, armed)
    `CHK("irq", 1'b1, irq)
    rd(`DRS_IRQ_ST_OFS); `CHK("irq status", 8'h03, v)
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h85, v)
    @(posedge ref_clk) drain <= 1'b1;
    load <= 1'b1;
    @(posedge ref_clk) load <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h85, v)
    `CHK("host left", 4'h0, left)
    @(posedge ref_clk) drain <= 1'b0;
    fill <= 4'h0;
    wr(`DRS_IRQ_ST_OFS, 8'h07);
    @(posedge ref_clk) #1 `CHK("irq", 1'b0, irq)
  endtask
  task automatic t_end;
    wr(`DRS_CTRL_OFS, 8'hc0);
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h20, v)
    @(posedge ref_clk) cmp_b <= 1'b1;
    full <= 1'b1;
    fill <= 4'h8;
    @(posedge ref_clk) cmp_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("armed", 1'b1, armed)
    @(posedge ref_clk) trig <= 1'b1;
    @(posedge ref_clk) trig <= 1'b0;
    full <= 1'b0;
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h48, v)
    @(posedge ref_clk) cmp_a <= 1'b1;
    @(posedge ref_clk) cmp_a <= 1'b0;
    rd(`DRS_STATUS_OFS); `CHK("idle match", 8'h48, v)
  endtask
  task automatic t_stop;
    wr(`DRS_CTRL_OFS, 8'hc0);
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h28, v)
    wr(`DRS_CTRL_OFS, 8'h80);
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h08, v)
    wr(`DRS_CTRL_OFS, 8'hc0);
    wr(`DRS_CTRL_OFS, 8'h40);
    rd(`DRS_STATUS_OFS); `CHK("status", 8'h08, v)
    @(posedge ref_clk) evo <= 1'b1;
    wr(`DRS_CTRL_OFS, 8'hc0);
    @(posedge ref_clk) full <= 1'b1;
    repeat (2) @(posedge ref_clk);
    full <= 1'b0;
    evo <= 1'b0;
    #1 `CHK("armed", 1'b0, armed)
    rd(`DRS_CTRL_OFS); `CHK("ctrl", 8'h80, v)
    rd(`DRS_IRQ_ST_OFS); `CHK("irq status", 8'h05, v)
    wr(`DRS_IRQ_MASK_OFS, 8'h00);
    #1 `CHK("irq masked", 1'b0, irq)
  endtask
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_begin();
    t_end();
    t_stop();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("ERROR watchdog expired");
    report_and_stop();
  end
endmodule // debug_run_status_tb
bind debug_run_status debug_run_status_properties chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .fifo_full(fifo_full), .trigger_event(trigger_event), .event_only_mode(event_only_mode),
  .run_armed(run_armed), .trace_begin_mode(trace_begin_mode), .run_start(run_start),
  .run_end(run_end), .irq(irq));
`default_nettype wire
